// File: mmd_defs.svh
// Purpose: address map and constants for the memory map decoder
// Assumes: 24-bit byte addresses, 16-bit words
// Notes: all figures of the map live here
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

`define MMD_LANES 4
`define MMD_BANKS 39
`define MMD_DUAL_PORT_RAM_BLKS 8
// cpu view
`define MMD_DUAL_PORT_RAM_HI 24'h00ffff
`define MMD_MMR_BYTES 24'h0000c0
`define MMD_SINGLE_PORT_RAM_LO 24'h010000
`define MMD_SINGLE_PORT_RAM_HI 24'h03ffff
`define MMD_RSVD_LO 24'h040000
`define MMD_EXT_LO 24'h050000
`define MMD_CS2_LO 24'h800000
`define MMD_CS3_LO 24'hc00000
`define MMD_CS4_LO 24'he00000
`define MMD_CS5_LO 24'hf00000
`define MMD_ROM_LO 24'hfe0000
// dma / usb alias view
`define MMD_DMA_DUAL_PORT_RAM_LO 24'h010000
`define MMD_DMA_DUAL_PORT_RAM_HI 24'h01ffff
`define MMD_DMA_SINGLE_PORT_RAM_LO 24'h090000
`define MMD_DMA_SINGLE_PORT_RAM_HI 24'h0bffff
// io word ranges open to dma
`define MMD_IO_EXTERNAL_MEMORY_PORT_LO 16'h1000
`define MMD_IO_EXTERNAL_MEMORY_PORT_HI 16'h10ff
`define MMD_IO_I2C_LO 16'h1a00
`define MMD_IO_I2C_HI 16'h1aff
`define MMD_IO_UART_LO 16'h1b00
`define MMD_IO_UART_HI 16'h1b7f
`define MMD_IO_I2S_LO 16'h2800
`define MMD_IO_I2S_HI 16'h2bff
`define MMD_IO_SD_LO 16'h3a00
`define MMD_IO_SD_HI 16'h3bff
`define MMD_IO_USB_LO 16'h8000
// bank numbering
`define MMD_BANK_SINGLE_PORT_RAM 6'h08
`define MMD_BANK_ROM 6'h20
`define MMD_BANK_EXT 6'h24
`define MMD_BANK_IO 6'h25
`define MMD_BANK_MMR 6'h26
`define MMD_BANK_NONE 6'h3f
// chip select encodings and idle level
`define MMD_CS_0 3'h0
`define MMD_CS_2 3'h1
`define MMD_CS_3 3'h2
`define MMD_CS_4 3'h3
`define MMD_CS_5 3'h4
`define MMD_CS_IDLE 5'h1f

`endif

// File: mmd_pkg.sv
// Purpose: types shared by the memory map decoder files
// Assumes: constants come from mmd_defs.svh
// Notes: lane order is fixed and used as an array index
package mmd_pkg;

typedef enum logic [1:0] {
	MMD_PROG = 2'h0,
	MMD_DATA = 2'h1,
	MMD_DMA = 2'h2,
	MMD_USB = 2'h3
} mmd_lane_t;

typedef struct packed {
	logic vld;
	logic we;
	logic io;
	logic [23:0] addr;
	logic [15:0] wdata;
} mmd_req_t;

typedef struct packed {
	logic [5:0] bank;
	logic [15:0] off;
	logic [2:0] cs;
} mmd_dec_t;

typedef struct packed {
	logic vld;
	logic we;
	logic [5:0] bank;
	logic port;
	logic [15:0] off;
	logic [15:0] wdata;
} mmd_route_t;

typedef struct packed {
	logic [1:0] ptr;
} mmd_arb_st_t;

typedef struct packed {
	logic rom_unmap;
	logic [3:0] ack;
	logic [3:0] p1;
	logic [3:0] z1;
	logic [3:0] p2;
	logic [3:0] z2;
	logic [3:0] rvld;
	logic [3:0][15:0] rdata;
	mmd_route_t [3:0] route;
	logic [4:0] cs_n;
	logic [20:0] ext_addr;
} mmd_st_t;

endpackage

// File: mmd_bank_arb.sv
// Purpose: per-bank arbiter granting up to CAP lanes a cycle
// Assumes: four request lanes
// Notes: rotating start point so no lane starves
`timescale 1ns/10ps
module mmd_bank_arb import mmd_pkg::*; #(
	parameter int CAP = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// lanes
	input wire logic [3:0] req,
	output logic [3:0] gnt,
	output logic [3:0] slot
);

	mmd_arb_st_t st_r;
	mmd_arb_st_t st_nxt;
	logic [1:0] k;
	logic [1:0] used;

	always_comb begin
		st_nxt = st_r;
		gnt = 4'h0;
		slot = 4'h0;
		used = 2'h0;
		k = 2'h0;
		for (int i = 0; i < 4; i++) begin
			k = st_r.ptr + 2'(i);
			if (req[k] && (int'(used) < CAP)) begin
				gnt[k] = 1'b1;
				// second grant takes the other port
				slot[k] = (used != 2'h0);
				used = used + 2'h1;
			end
		end
		// move the start only when someone had to wait
		if ((req & ~gnt) != 4'h0)
			st_nxt.ptr = st_r.ptr + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

endmodule

// File: mmd_decoder.sv
// Purpose: memory map decoder and router for cpu, dma and usb lanes
// Assumes: one clock; requests come from same-clock logic
// Notes: a lane holds its request until ack; results land 2 cycles after ack
//
// How it works
// - cpu bytes 000000h-00FFFFh go to eight dual-port ram blocks
// - a dual-port block takes two accesses a cycle, any mix
// - dma reaches dual-port ram at the 0001 0000h alias
// - first 192 bytes of block zero are mapped registers, not ram
// - cpu bytes 010000h-03FFFFh go to 24 single-port ram blocks
// - a single-port block takes one access a cycle
// - dma and usb reach single-port ram at the 0009 0000h alias
// - usb dma lane gets a path to single-port ram
// - 040000h-04FFFFh and its 000C 0000h alias hold nothing
// - FE0000h-FFFFFFh select four rom blocks, no wait states
// - rom unmap bit set leaves the top range unmapped
// - hardware reset clears rom unmap bit; soft reset leaves it
// - only program and data lanes reach the rom
// - 050000h-FDFFFFh is external space in five chip select regions
// - a chip select goes active for accesses in its region
// - external port: 16 or 8 bit data, up to 21 address bits
// - separate 64K io space, reached by io accesses of the data lane or dma
// - dma reaches io registers of the listed peripherals
// - cpu addresses one 16M byte program and data space
// - unmapped reads return zero, unmapped writes do nothing
// - usb lane never reaches dual-port ram
`timescale 1ns/10ps
`include "mmd_defs.svh"
module mmd_decoder import mmd_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// master lanes: program, data, dma, usb
	input wire mmd_req_t [3:0] mst_req,
	output logic [3:0] mst_ack,
	output logic [3:0] mst_rvld,
	output logic [3:0][15:0] mst_rdata,
	// memory fabric side
	output mmd_route_t [3:0] mem_route,
	input wire logic [3:0][15:0] mem_rdata,
	// external memory port
	input wire logic ext_bus8,
	output logic [4:0] external_chip_select_n,
	output logic [20:0] ext_addr,
	// cpu status word three, rom unmap field
	input wire logic st3_wr,
	input wire logic st3_rom_unmap,
	output logic rom_unmap_bit
);

	mmd_st_t st_r;
	mmd_st_t st_nxt;
	mmd_dec_t [3:0] dec;
	logic [3:0] live;
	logic [3:0] take;
	logic [3:0] port;
	logic [`MMD_BANKS-1:0][3:0] breq;
	logic [`MMD_BANKS-1:0][3:0] bgnt;
	logic [`MMD_BANKS-1:0][3:0] bslot;

	// io words the dma controllers may touch
	function automatic logic io_dma_ok(input logic [15:0] w);
		logic ok;
		ok = 1'b0;
		if (w >= `MMD_IO_EXTERNAL_MEMORY_PORT_LO && w <= `MMD_IO_EXTERNAL_MEMORY_PORT_HI)
			ok = 1'b1;
		if (w >= `MMD_IO_I2C_LO && w <= `MMD_IO_I2C_HI)
			ok = 1'b1;
		if (w >= `MMD_IO_UART_LO && w <= `MMD_IO_UART_HI)
			ok = 1'b1;
		if (w >= `MMD_IO_I2S_LO && w <= `MMD_IO_I2S_HI)
			ok = 1'b1;
		if (w >= `MMD_IO_SD_LO && w <= `MMD_IO_SD_HI)
			ok = 1'b1;
		if (w >= `MMD_IO_USB_LO)
			ok = 1'b1;
		return ok;
	endfunction

	// chip select region of an external address
	function automatic logic [2:0] ext_region(input logic [23:0] a);
		logic [2:0] r;
		r = `MMD_CS_0;
		if (a >= `MMD_CS2_LO)
			r = `MMD_CS_2;
		if (a >= `MMD_CS3_LO)
			r = `MMD_CS_3;
		if (a >= `MMD_CS4_LO)
			r = `MMD_CS_4;
		if (a >= `MMD_CS5_LO)
			r = `MMD_CS_5;
		return r;
	endfunction

	// full map decode for one lane
	function automatic mmd_dec_t decode(input mmd_lane_t lane,
		input mmd_req_t q, input logic unmap);
		mmd_dec_t d;
		logic [23:0] a;
		logic [23:0] s;
		logic cpu;
		a = q.addr;
		s = 24'h000000;
		cpu = (lane == MMD_PROG) || (lane == MMD_DATA);
		d.bank = `MMD_BANK_NONE;
		d.off = {4'h0, a[12:1]};
		d.cs = `MMD_CS_0;
		if (q.io) begin
			// io space only from data lane or dma
			d.off = a[15:0];
			if (lane == MMD_DATA)
				d.bank = `MMD_BANK_IO;
			if (lane == MMD_DMA && io_dma_ok(a[15:0]))
				d.bank = `MMD_BANK_IO;
		end else if (!cpu) begin
			if (lane == MMD_DMA && a >= `MMD_DMA_DUAL_PORT_RAM_LO &&
				a <= `MMD_DMA_DUAL_PORT_RAM_HI) begin
				s = a - `MMD_DMA_DUAL_PORT_RAM_LO;
				d.bank = {3'h0, s[15:13]};
				if (s < `MMD_MMR_BYTES)
					d.bank = `MMD_BANK_MMR;
			end
			if (a >= `MMD_DMA_SINGLE_PORT_RAM_LO && a <= `MMD_DMA_SINGLE_PORT_RAM_HI) begin
				s = a - `MMD_DMA_SINGLE_PORT_RAM_LO;
				d.bank = `MMD_BANK_SINGLE_PORT_RAM + s[18:13];
			end
			// alias reserved window falls to none
			// no rom path on these lanes
		end else begin
			// cpu sees the whole 24-bit byte space
			if (a <= `MMD_DUAL_PORT_RAM_HI) begin
				d.bank = {3'h0, a[15:13]};
				if (a < `MMD_MMR_BYTES)
					d.bank = `MMD_BANK_MMR;
			end else if (a >= `MMD_SINGLE_PORT_RAM_LO && a <= `MMD_SINGLE_PORT_RAM_HI) begin
				s = a - `MMD_SINGLE_PORT_RAM_LO;
				d.bank = `MMD_BANK_SINGLE_PORT_RAM + s[18:13];
			end else if (a >= `MMD_ROM_LO) begin
				// unmapped while the bit is set
				if (!unmap) begin
					d.bank = `MMD_BANK_ROM + {4'h0, a[16:15]};
					d.off = a[16:1];
				end
			end else if (a >= `MMD_EXT_LO) begin
				// five regions above the on-chip map
				d.bank = `MMD_BANK_EXT;
				d.cs = ext_region(a);
			end
		end
		return d;
	endfunction

	// decode and hold-off of lanes just acked
	always_comb begin
		for (int m = 0; m < `MMD_LANES; m++) begin
			dec[m] = decode(mmd_lane_t'(m), mst_req[m], st_r.rom_unmap);
			// a request seen in its ack cycle is the old one
			live[m] = mst_req[m].vld && !st_r.ack[m];
		end
	end

	// one arbiter per bank
	genvar b;
	generate
		for (b = 0; b < `MMD_BANKS; b++) begin : g_bank
			always_comb begin
				for (int m = 0; m < `MMD_LANES; m++)
					breq[b][m] = live[m] && (dec[m].bank == 6'(b));
			end
			mmd_bank_arb #(
				.CAP((b < `MMD_DUAL_PORT_RAM_BLKS) ? 2 : 1)
			) u_arb (
				.clk(clk),
				.rst(rst),
				.req(breq[b]),
				.gnt(bgnt[b]),
				.slot(bslot[b])
			);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		take = 4'h0;
		port = 4'h0;
		st_nxt.cs_n = `MMD_CS_IDLE;
		for (int m = 0; m < `MMD_LANES; m++) begin
			for (int k = 0; k < `MMD_BANKS; k++) begin
				take[m] = take[m] | bgnt[k][m];
				port[m] = port[m] | bslot[k][m];
			end
			// unmapped is taken at once with no effect
			if (live[m] && dec[m].bank == `MMD_BANK_NONE)
				take[m] = 1'b1;
			st_nxt.ack[m] = take[m];
			st_nxt.route[m].vld = take[m] &&
				(dec[m].bank != `MMD_BANK_NONE);
			// program lane only fetches
			st_nxt.route[m].we = mst_req[m].we &&
				(mmd_lane_t'(m) != MMD_PROG);
			st_nxt.route[m].bank = dec[m].bank;
			st_nxt.route[m].port = port[m];
			st_nxt.route[m].off = dec[m].off;
			st_nxt.route[m].wdata = mst_req[m].wdata;
			// read pipeline: route, memory, result
			st_nxt.p1[m] = take[m] && !st_nxt.route[m].we;
			st_nxt.z1[m] = dec[m].bank == `MMD_BANK_NONE;
			st_nxt.p2[m] = st_r.p1[m];
			st_nxt.z2[m] = st_r.z1[m];
			st_nxt.rvld[m] = st_r.p2[m];
			if (st_r.p2[m]) begin
				// unmapped reads come back as zero
				st_nxt.rdata[m] = st_r.z2[m] ? 16'h0000 : mem_rdata[m];
			end
			if (take[m] && dec[m].bank == `MMD_BANK_EXT) begin
				// select line of the hit region
				st_nxt.cs_n[dec[m].cs] = 1'b0;
				// byte or word address on the port
				if (ext_bus8)
					st_nxt.ext_addr = mst_req[m].addr[20:0];
				else
					st_nxt.ext_addr = {1'b0, mst_req[m].addr[20:1]};
			end
		end
		// only software writes touch it after reset
		if (st3_wr)
			st_nxt.rom_unmap = st3_rom_unmap;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// hardware reset brings the rom back
			st_r <= '0;
			st_r.cs_n <= `MMD_CS_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mst_ack = st_r.ack;
	assign mst_rvld = st_r.rvld;
	assign mst_rdata = st_r.rdata;
	assign mem_route = st_r.route;
	assign external_chip_select_n = st_r.cs_n;
	assign ext_addr = st_r.ext_addr;
	assign rom_unmap_bit = st_r.rom_unmap;

endmodule

// File: mmd_decoder_properties.sv
// Purpose: port checks for the memory map decoder
// Assumes: ack and route share a cycle; reads land 2 cycles on
// Notes: bound to every mmd_decoder
`timescale 1ns/10ps
module mmd_decoder_properties import mmd_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// lanes
	input wire mmd_req_t [3:0] mst_req,
	input wire logic [3:0] mst_ack,
	input wire logic [3:0] mst_rvld,
	input wire logic [3:0][15:0] mst_rdata,
	// fabric and pins
	input wire mmd_route_t [3:0] mem_route,
	input wire logic [3:0][15:0] mem_rdata,
	input wire logic ext_bus8,
	input wire logic [4:0] external_chip_select_n,
	input wire logic [20:0] ext_addr,
	input wire logic st3_wr,
	input wire logic st3_rom_unmap,
	input wire logic rom_unmap_bit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_ACK_PULSE: assert property (
		(mst_ack & $past(mst_ack)) == 4'h0) else $error("ack too long");
	AST_RD_LAT: assert property (
		mst_ack[1] && !$past(mst_req[1].we) |-> ##2 mst_rvld[1])
		else $error("read result late");
	AST_RD_DATA: assert property (
		mst_rvld[1] && $past(mem_route[1].vld, 2) |->
		mst_rdata[1] == $past(mem_rdata[1])) else $error("read data lost");
	AST_RD_ZERO: assert property (
		mst_rvld[1] && !$past(mem_route[1].vld, 2) |->
		mst_rdata[1] == 16'h0) else $error("unmapped read not zero");
	AST_USB_NO_DP: assert property (
		mem_route[3].vld |-> mem_route[3].bank > 6'h07)
		else $error("usb in dual-port ram");
	AST_DMA_NO_ROM: assert property (
		mem_route[2].vld |-> !(mem_route[2].bank inside {[6'h20:6'h23]}))
		else $error("dma in rom");
	AST_ROM_GONE: assert property (
		$past(rom_unmap_bit) && mem_route[1].vld |->
		!(mem_route[1].bank inside {[6'h20:6'h23]})) else $error("rom seen");
	AST_UNMAP_SET: assert property (
		st3_wr |=> rom_unmap_bit == $past(st3_rom_unmap))
		else $error("unmap bit not written");
	AST_UNMAP_HOLD: assert property (
		!st3_wr |=> $stable(rom_unmap_bit)) else $error("unmap bit moved");
	AST_CS_ROUTE: assert property (
		external_chip_select_n != 5'h1f |->
		$onehot(~external_chip_select_n) &&
		((mem_route[0].vld && mem_route[0].bank == 6'h24) ||
		(mem_route[1].vld && mem_route[1].bank == 6'h24)))
		else $error("chip select without external route");
	cover property (mst_rvld[1]);
	cover property (!external_chip_select_n[4]);
	cover property (rom_unmap_bit && mst_ack[1]);
endmodule
bind mmd_decoder mmd_decoder_properties chk_u (.clk, .rst, .mst_req,
	.mst_ack, .mst_rvld, .mst_rdata, .mem_route, .mem_rdata, .ext_bus8,
	.external_chip_select_n, .ext_addr, .st3_wr, .st3_rom_unmap,
	.rom_unmap_bit);

// File: mmd_mem_model.sv
// Purpose: fabric stand-in answering decoder routes
// Assumes: one-cycle synchronous read per lane
// Notes: unwritten words read as offset xor 5a5a
`timescale 1ns/10ps
module mmd_mem_model import mmd_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// routes in, read data out
	input wire mmd_route_t [3:0] mem_route,
	output logic [3:0][15:0] mem_rdata
);
	logic [15:0] store [logic [21:0]];
	logic [21:0] k;
	always @(posedge clk) begin
		for (int m = 0; m < 4; m++) begin
			k = {mem_route[m].bank, mem_route[m].off};
			if (rst) begin
				mem_rdata[m] <= 16'h0;
			end else if (!mem_route[m].vld) begin
				// idle lanes toggle so stale data never passes
				mem_rdata[m] <= ~mem_rdata[m];
			end else if (mem_route[m].we) begin
				store[k] = mem_route[m].wdata;
			end else begin
				mem_rdata[m] <= store.exists(k) ? store[k] :
					k[15:0] ^ 16'h5a5a;
			end
		end
	end
endmodule

// File: mmd_decoder_test.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: bank and chip select numbering of the decoder
// Notes: lanes driven on the falling edge, sampled just after rise
`timescale 1ns/10ps
module mmd_decoder_test import mmd_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	mmd_req_t [3:0] mst_req = '0;
	logic [3:0] mst_ack, mst_rvld;
	logic [3:0][15:0] mst_rdata, mem_rdata;
	mmd_route_t [3:0] mem_route;
	logic [4:0] external_chip_select_n, cs_seen;
	logic [20:0] ext_addr;
	logic ext_bus8 = 1'b0;
	logic st3_wr = 1'b0;
	logic st3_rom_unmap = 1'b0;
	logic rom_unmap_bit;
	int miscompares = 0;
	int samples_checked = 0;
	mmd_decoder dut_u (.clk, .rst, .mst_req, .mst_ack, .mst_rvld, .mst_rdata,
		.mem_route, .mem_rdata, .ext_bus8, .external_chip_select_n,
		.ext_addr, .st3_wr, .st3_rom_unmap, .rom_unmap_bit);
	mmd_mem_model mem_u (.clk, .rst, .mem_route, .mem_rdata);
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one word on lane l: hold until ack, drop in the ack cycle
	task automatic acc(input int l, input logic we, input logic io,
		input logic [23:0] a, input logic [15:0] wd, output mmd_route_t rt,
		output logic [15:0] rd, output time ta);
		int n;
		n = 0;
		rd = 16'h0;
		@(negedge clk);
		mst_req[l] = {1'b1, we, io, a, wd};
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (mst_ack[l] !== 1'b1 && n < 16);
		check(n < 16, 1);
		rt = mem_route[l];
		cs_seen = external_chip_select_n;
		ta = $time;
		@(negedge clk);
		mst_req[l].vld = 1'b0;
		if (!we) begin
			repeat (2) @(posedge clk);
			#1;
			check(mst_rvld[l], 1);
			rd = mst_rdata[l];
		end
	endtask
	task automatic probe(input int l, input logic io, input logic [23:0] a,
		input logic [6:0] eb);
		mmd_route_t rt;
		logic [15:0] rd;
		time ta;
		acc(l, 1'b0, io, a, 16'h0, rt, rd, ta);
		check({rt.vld, rt.bank}, eb);
		if (!eb[6]) check(rd, 16'h0);
	endtask
	task automatic t_map();
		probe(1, 0, 24'h000010, 7'h66);
		probe(1, 0, 24'h0000c0, 7'h40);
		probe(1, 0, 24'h00fffe, 7'h47);
		probe(2, 0, 24'h016010, 7'h43);
		probe(1, 0, 24'h010000, 7'h48);
		probe(2, 0, 24'h0be000, 7'h5f);
		probe(3, 0, 24'h010000, 7'h3f);
		probe(1, 0, 24'h040000, 7'h3f);
		probe(2, 0, 24'h0c0000, 7'h3f);
		probe(2, 0, 24'hfe0000, 7'h3f);
		probe(2, 0, 24'h010010, 7'h66);
		probe(1, 1, 24'h001b00, 7'h65);
		probe(0, 1, 24'h001b00, 7'h3f);
		probe(2, 1, 24'h001a00, 7'h65);
		probe(2, 1, 24'h001800, 7'h3f);
		$display("map test done");
	endtask
	task automatic t_par();
		mmd_route_t r1, r2;
		logic [15:0] d1, d2;
		time t1, t2;
		acc(1, 1, 0, 24'h006010, 16'hbeef, r1, d1, t1);
		fork
			acc(1, 0, 0, 24'h006010, 16'h0, r1, d1, t1);
			acc(2, 0, 0, 24'h016010, 16'h0, r2, d2, t2);
		join
		check(d1, 16'hbeef);
		check(d2, 16'hbeef);
		check(t1 == t2, 1);
		check(r1.port ^ r2.port, 1);
		acc(3, 1, 0, 24'h090002, 16'h1234, r1, d1, t1);
		fork
			acc(1, 0, 0, 24'h010002, 16'h0, r1, d1, t1);
			acc(3, 0, 0, 24'h090002, 16'h0, r2, d2, t2);
		join
		check(d1, 16'h1234);
		check(d2, 16'h1234);
		check(t1 != t2, 1);
		check(r1.off, 16'h0001);
		$display("contention test done");
	endtask
	task automatic t_ext();
		logic [23:0] a [5] = '{24'h050000, 24'h800000, 24'hc00000,
			24'he00000, 24'hf00000};
		logic [4:0] m;
		mmd_route_t rt;
		logic [15:0] rd;
		time ta;
		@(negedge clk);
		ext_bus8 = 1'b0;
		for (int i = 0; i < 5; i++) begin
			acc(1, 1, 0, a[i], 16'h0, rt, rd, ta);
			m = ~(5'h01 << i);
			check({rt.vld, rt.bank}, 7'h64);
			check(cs_seen, m);
			check(ext_addr, {1'b0, a[i][20:1]});
		end
		@(negedge clk);
		ext_bus8 = 1'b1;
		acc(1, 0, 0, 24'h0a1235, 16'h0, rt, rd, ta);
		check(cs_seen, 5'h1e);
		check(ext_addr, 21'h0a1235);
		$display("external test done");
	endtask
	task automatic t_rom();
		mmd_route_t rt;
		logic [15:0] rd;
		time ta;
		acc(1, 0, 0, 24'hfffffe, 16'h0, rt, rd, ta);
		check({rt.vld, rt.bank}, 7'h63);
		check(rd, 16'ha5a5);
		@(negedge clk);
		st3_wr = 1'b1;
		st3_rom_unmap = 1'b1;
		@(negedge clk);
		st3_wr = 1'b0;
		check(rom_unmap_bit, 1);
		probe(1, 0, 24'hfe0000, 7'h3f);
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check(rom_unmap_bit, 0);
		probe(0, 0, 24'hfe0000, 7'h60);
		$display("rom test done");
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_map();
		t_par();
		t_ext();
		t_rom();
		tally_and_finish();
	end
	initial begin
		#20000;
		miscompares++;
		tally_and_finish();
	end
endmodule
